// File: rtl/fault_retry_pkg.sv
// Shared constants and types for the fault retry manager and its action decoder.
// Assumes a single 40 MHz clock and an APB slave with 32-bit data.
package fault_retry_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int NORMAL_RUN_S = 60;
    localparam int NORMAL_RUN_TICKS = NORMAL_RUN_S * 1000 / TICK_MS;

    // Setting ranges and reset values; the interval counts 0.1 s steps.
    localparam logic [3:0] LIMIT_MAX = 4'ha;
    localparam logic [3:0] LIMIT_RESET = 4'h0;
    localparam logic CONTACT_RESET = 1'b0;
    localparam logic [12:0] INTERVAL_MIN = 13'h0005;
    localparam logic [12:0] INTERVAL_MAX = 13'h1770;
    localparam logic [12:0] INTERVAL_RESET = 13'h0064;
    localparam logic [2:0] CODE_MAX = 3'h4;
    localparam logic [2:0] PID_DIGIT_RESET = 3'h0;
    localparam logic [2:0] MEM_DIGIT_RESET = 3'h1;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_PID_ACT = 8'h08;
    localparam logic [7:0] ADDR_MEM_ACT = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1c;

    // Field positions.
    localparam int CTRL_LIMIT_LSB = 0;
    localparam int CTRL_CONTACT_BIT = 4;
    localparam int DIGIT_STRIDE = 4;
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_RESTART_BIT = 1;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_CONTACT_BIT = 8;
    localparam int STAT_HOLD_BIT = 9;
    localparam int IRQ_RETRY = 0;
    localparam int IRQ_LOCK = 1;
    localparam int IRQ_RESTART = 2;
    localparam int IRQ_CLEARED = 3;
    localparam int IRQ_ALARM = 4;
    localparam int IRQ_W = 5;

    // Fault codes that never retry, one bit per code number.
    localparam logic [63:0] NONRETRY_MASK = 64'h000c08ac_0cf7cf00;

    typedef enum logic [2:0] {
        ACT_NONE,
        ACT_ALARM,
        ACT_STOP,
        ACT_ESTOP,
        ACT_COAST
    } action_code_t;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_WAIT,
        ST_DIAG,
        ST_WATCH,
        ST_LOCKED
    } retry_state_t;

    typedef struct packed {
        logic alarm;
        logic stop;
        logic estop;
        logic coast;
        logic emg_decel;
    } prot_action_t;

    typedef struct packed {
        retry_state_t st;
        logic [3:0] count;
        logic [3:0] limit;
        logic contact_sel;
        logic [12:0] interval;
        logic [2:0][2:0] pid_codes;
        logic [1:0][2:0] mem_codes;
        logic [31:0] presc;
        logic [12:0] icnt;
        logic [9:0] wcnt;
        logic restart;
        prot_action_t prot;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
    } retry_regs_t;

endpackage : fault_retry_pkg

// File: rtl/protection_action_decoder.sv
// Decodes one protection-action code against one detector level.
// Assumes the detector level is synchronous and the code is a stored setting.
`timescale 1ns/10ps
module protection_action_decoder
(
    // Setting and condition
    input wire logic [2:0] code,
    input wire logic detect,
    input wire logic decel_stop_mode,
    // Resulting action
    output fault_retry_pkg::prot_action_t act
);

    always_comb
    begin
        act = '0;
        if (detect)
        begin
            unique case (code)
                fault_retry_pkg::ACT_NONE:
                begin
                    act = '0;
                end
                fault_retry_pkg::ACT_ALARM:
                begin
                    act.alarm = 1'b1;
                end
                fault_retry_pkg::ACT_STOP:
                begin
                    act.alarm = 1'b1;
                    act.stop = 1'b1;
                end
                fault_retry_pkg::ACT_ESTOP:
                begin
                    act.alarm = 1'b1;
                    act.estop = 1'b1;
                    act.emg_decel = decel_stop_mode;
                end
                fault_retry_pkg::ACT_COAST:
                begin
                    act.coast = 1'b1;
                end
                default:
                begin
                    // Codes above four cannot be stored; treat as no detection.
                    act = '0;
                end
            endcase
        end
    end

endmodule : protection_action_decoder

// File: rtl/fault_retry_manager.sv
// Fault retry sequencing, retry counter, fault contact and protection actions.
// Assumes synchronous inputs, an APB master and external fault detectors.
`timescale 1ns/10ps
// Summary of operation
// - Restart with speed search after clean diagnosis
// - Retry limit zero to ten, zero disables
// - Limit reached: stop until manual restart or fault reset
// - Listed fault codes never retry
// - One minute normal run clears counter
// - Fault reset after latched fault clears counter
// - Power cycle clears counter
// - Contact select drives fault contact during retry
// - Retry interval 0.5 s to 600 s
// - Interval only used when limit above zero
// - Action codes: none, alarm, stop, estop, coast
// - Code 3 with decel stop uses emergency decel
// - PID digits: reference, feedback, error actions
// - Memory digits: EEPROM, FRAM; default eleven
// - Code 0 takes no action; code 1 only raises the alarm
module fault_retry_manager
#(
    parameter int TICK_CYCLES = fault_retry_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive status and fault report
    input wire logic running,
    input wire logic fault_trip,
    input wire logic [5:0] fault_code,
    input wire logic fault_reset,
    input wire logic manual_restart,
    // Self-diagnosis handshake
    output logic diag_req,
    input wire logic diag_done,
    input wire logic diag_ok,
    input wire logic cause_cleared,
    // Detectors and stop mode
    input wire logic pid_ref_loss,
    input wire logic pid_fb_loss,
    input wire logic pid_err_abn,
    input wire logic eeprom_err,
    input wire logic fram_err,
    input wire logic decel_stop_mode,
    // Drive commands and indications
    output logic speed_search_start,
    output logic stop_hold,
    output logic fault_contact,
    output logic alarm,
    output logic stop_req,
    output logic estop_req,
    output logic coast_req,
    output logic emergency_decel_sel,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State, helpers and decoders

    fault_retry_pkg::retry_regs_t s;
    fault_retry_pkg::retry_regs_t next_s;
    fault_retry_pkg::prot_action_t acts [5];
    fault_retry_pkg::prot_action_t prot_any;
    logic [4:0] detects;
    logic [4:0][2:0] codes;
    logic tick;
    logic wr;
    logic rd_setup;
    logic nonretry;
    logic retry_ok;
    logic any_reset;
    logic any_restart;
    logic trip_here;
    logic wait_done;
    localparam int IRQ_W_L = fault_retry_pkg::IRQ_W;

    function automatic logic [2:0] sat_code(input logic [3:0] d);
        sat_code = (d > {1'b0, fault_retry_pkg::CODE_MAX}) ? fault_retry_pkg::CODE_MAX : d[2:0];
    endfunction : sat_code

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= fault_retry_pkg::ADDR_CMD) && (a[1:0] == 2'h0);
    endfunction : addr_ok

    function automatic logic [11:0] pack_digits(input logic [2:0][2:0] c);
        pack_digits = {1'b0, c[2], 1'b0, c[1], 1'b0, c[0]};
    endfunction : pack_digits

    assign detects = {fram_err, eeprom_err, pid_err_abn, pid_fb_loss, pid_ref_loss};
    // Digit order puts reference, feedback, error, EEPROM, FRAM on detectors 0 to 4.
    assign codes = {s.mem_codes[1], s.mem_codes[0], s.pid_codes};

    for (genvar i = 0; i < 5; i++)
    begin : g_dec
        protection_action_decoder u_dec
        (
            .code(codes[i]),
            .detect(detects[i]),
            .decel_stop_mode(decel_stop_mode),
            .act(acts[i])
        );
    end

    assign tick = (s.presc == 32'(TICK_CYCLES - 1));
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign nonretry = fault_retry_pkg::NONRETRY_MASK[fault_code];
    assign retry_ok = (s.limit != 4'h0) && (s.count < s.limit) && !nonretry;
    assign any_reset = fault_reset
        || (wr && paddr == fault_retry_pkg::ADDR_CMD && pwdata[fault_retry_pkg::CMD_RESET_BIT]);
    assign any_restart = manual_restart
        || (wr && paddr == fault_retry_pkg::ADDR_CMD && pwdata[fault_retry_pkg::CMD_RESTART_BIT]);
    assign trip_here = fault_trip
        && (s.st == fault_retry_pkg::ST_NORMAL || s.st == fault_retry_pkg::ST_WATCH);
    assign wait_done = tick && (s.icnt + 13'h0001 >= s.interval);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        logic [IRQ_W_L-1:0] set_irq;
        logic [IRQ_W_L-1:0] clr_irq;
        set_irq = '0;
        clr_irq = '0;
        next_s = s;
        next_s.restart = 1'b0;
        next_s.presc = tick ? 32'h0 : s.presc + 32'h1;

        prot_any = '0;
        for (int i = 0; i < 5; i++)
        begin
            prot_any = prot_any | acts[i];
        end
        next_s.prot = prot_any;
        set_irq[fault_retry_pkg::IRQ_ALARM] = prot_any.alarm && !s.prot.alarm;

        unique case (s.st)
            fault_retry_pkg::ST_NORMAL, fault_retry_pkg::ST_WATCH:
            begin
                if (trip_here)
                begin
                    if (running && retry_ok)
                    begin
                        // Interval timer starts from a fresh prescaler at the trip.
                        next_s.st = fault_retry_pkg::ST_WAIT;
                        next_s.count = s.count + 4'h1;
                        next_s.icnt = '0;
                        next_s.presc = '0;
                        set_irq[fault_retry_pkg::IRQ_RETRY] = 1'b1;
                    end
                    else
                    begin
                        next_s.st = fault_retry_pkg::ST_LOCKED;
                        set_irq[fault_retry_pkg::IRQ_LOCK] = 1'b1;
                    end
                end
                else if (s.st == fault_retry_pkg::ST_WATCH && tick)
                begin
                    if (!running)
                    begin
                        // A stop ends the watch without crediting normal running.
                        next_s.st = fault_retry_pkg::ST_NORMAL;
                    end
                    else if (s.wcnt == 10'(fault_retry_pkg::NORMAL_RUN_TICKS - 1))
                    begin
                        next_s.st = fault_retry_pkg::ST_NORMAL;
                        next_s.count = '0;
                        set_irq[fault_retry_pkg::IRQ_CLEARED] = 1'b1;
                    end
                    else
                    begin
                        next_s.wcnt = s.wcnt + 10'h001;
                    end
                end
            end
            fault_retry_pkg::ST_WAIT:
            begin
                if (wait_done)
                begin
                    next_s.st = fault_retry_pkg::ST_DIAG;
                end
                else if (tick)
                begin
                    next_s.icnt = s.icnt + 13'h0001;
                end
            end
            fault_retry_pkg::ST_DIAG:
            begin
                if (diag_done)
                begin
                    if (diag_ok && cause_cleared)
                    begin
                        next_s.st = fault_retry_pkg::ST_WATCH;
                        next_s.restart = 1'b1;
                        next_s.wcnt = '0;
                        next_s.presc = '0;
                        set_irq[fault_retry_pkg::IRQ_RESTART] = 1'b1;
                    end
                    else
                    begin
                        next_s.st = fault_retry_pkg::ST_LOCKED;
                        set_irq[fault_retry_pkg::IRQ_LOCK] = 1'b1;
                    end
                end
            end
            fault_retry_pkg::ST_LOCKED:
            begin
                if (any_reset)
                begin
                    next_s.st = fault_retry_pkg::ST_NORMAL;
                    next_s.count = '0;
                    set_irq[fault_retry_pkg::IRQ_CLEARED] = 1'b1;
                end
                else if (any_restart)
                begin
                    next_s.st = fault_retry_pkg::ST_NORMAL;
                end
            end
        endcase

        // Register writes.
        if (wr)
        begin
            unique case (paddr)
                fault_retry_pkg::ADDR_CTRL:
                begin
                    next_s.limit = (pwdata[3:0] > fault_retry_pkg::LIMIT_MAX)
                        ? fault_retry_pkg::LIMIT_MAX : pwdata[3:0];
                    next_s.contact_sel = pwdata[fault_retry_pkg::CTRL_CONTACT_BIT];
                end
                fault_retry_pkg::ADDR_INTERVAL:
                begin
                    if (pwdata[12:0] < fault_retry_pkg::INTERVAL_MIN || pwdata[31:13] != '0)
                    begin
                        next_s.interval = (pwdata[31:13] != '0)
                            ? fault_retry_pkg::INTERVAL_MAX : fault_retry_pkg::INTERVAL_MIN;
                    end
                    else if (pwdata[12:0] > fault_retry_pkg::INTERVAL_MAX)
                    begin
                        next_s.interval = fault_retry_pkg::INTERVAL_MAX;
                    end
                    else
                    begin
                        next_s.interval = pwdata[12:0];
                    end
                end
                fault_retry_pkg::ADDR_PID_ACT:
                begin
                    for (int d = 0; d < 3; d++)
                    begin
                        next_s.pid_codes[d] = sat_code(pwdata[d*4 +: 4]);
                    end
                end
                fault_retry_pkg::ADDR_MEM_ACT:
                begin
                    for (int d = 0; d < 2; d++)
                    begin
                        next_s.mem_codes[d] = sat_code(pwdata[d*4 +: 4]);
                    end
                end
                fault_retry_pkg::ADDR_IRQ_STAT:
                begin
                    clr_irq = pwdata[IRQ_W_L-1:0];
                end
                fault_retry_pkg::ADDR_IRQ_MASK:
                begin
                    next_s.irq_mask = pwdata[IRQ_W_L-1:0];
                end
                default:
                begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        next_s.irq_stat = (s.irq_stat & ~clr_irq) | set_irq;

        // Read data is captured in the setup cycle so it leaves a flop.
        if (rd_setup)
        begin
            unique case (paddr)
                fault_retry_pkg::ADDR_CTRL:
                    next_s.prdata = {27'h0, s.contact_sel, s.limit};
                fault_retry_pkg::ADDR_INTERVAL:
                    next_s.prdata = {19'h0, s.interval};
                fault_retry_pkg::ADDR_PID_ACT:
                    next_s.prdata = {20'h0, pack_digits(s.pid_codes)};
                fault_retry_pkg::ADDR_MEM_ACT:
                    next_s.prdata = {24'h0, 1'b0, s.mem_codes[1], 1'b0, s.mem_codes[0]};
                fault_retry_pkg::ADDR_STATUS:
                    next_s.prdata = {22'h0, stop_hold, fault_contact, 1'b0, s.st, s.count};
                fault_retry_pkg::ADDR_IRQ_STAT:
                    next_s.prdata = {27'h0, s.irq_stat};
                fault_retry_pkg::ADDR_IRQ_MASK:
                    next_s.prdata = {27'h0, s.irq_mask};
                default:
                    next_s.prdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Power-on reset is the only way a power cycle reaches the counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{
                st: fault_retry_pkg::ST_NORMAL,
                limit: fault_retry_pkg::LIMIT_RESET,
                contact_sel: fault_retry_pkg::CONTACT_RESET,
                interval: fault_retry_pkg::INTERVAL_RESET,
                pid_codes: {3{fault_retry_pkg::PID_DIGIT_RESET}},
                mem_codes: {2{fault_retry_pkg::MEM_DIGIT_RESET}},
                default: '0
            };
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign diag_req = (s.st == fault_retry_pkg::ST_DIAG);
    assign speed_search_start = s.restart;
    assign stop_hold = (s.st == fault_retry_pkg::ST_LOCKED);
    // During a retry the contact follows the selection; a latched fault always drives it.
    assign fault_contact = stop_hold
        || ((s.st == fault_retry_pkg::ST_WAIT || s.st == fault_retry_pkg::ST_DIAG)
        && s.contact_sel);
    assign alarm = s.prot.alarm;
    assign stop_req = s.prot.stop;
    assign estop_req = s.prot.estop;
    assign coast_req = s.prot.coast;
    assign emergency_decel_sel = s.prot.emg_decel;
    assign irq = |(s.irq_stat & s.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_clean_diag;
        s.st == fault_retry_pkg::ST_DIAG && diag_done && diag_ok && cause_cleared;
    endsequence

    sequence s_retry_trip;
        trip_here && running && retry_ok;
    endsequence

    chk_restart_after_diag: assert property (s_clean_diag |=> speed_search_start ##1 !speed_search_start)
        else $error("restart did not follow clean diagnosis");
    chk_limit_range: assert property (s.limit <= fault_retry_pkg::LIMIT_MAX)
        else $error("retry limit out of range");
    chk_lock_at_limit: assert property (trip_here && s.count == s.limit |=> stop_hold)
        else $error("fault at limit did not lock");
    chk_nonretry_lock: assert property (trip_here && nonretry |=> stop_hold && fault_contact)
        else $error("non-retryable fault did not lock");
    chk_watch_clear: assert property (s.st == fault_retry_pkg::ST_WATCH && tick && running
        && !fault_trip && s.wcnt == 10'(fault_retry_pkg::NORMAL_RUN_TICKS - 1)
        |=> s.count == 4'h0 && s.st == fault_retry_pkg::ST_NORMAL)
        else $error("normal run did not clear counter");
    chk_reset_clear: assert property (stop_hold && any_reset |=> s.count == 4'h0 && !stop_hold)
        else $error("fault reset did not clear counter");
    chk_contact_retry: assert property (s_retry_trip |=> fault_contact == s.contact_sel)
        else $error("fault contact wrong during retry");
    chk_interval_range: assert property (s.interval >= fault_retry_pkg::INTERVAL_MIN
        && s.interval <= fault_retry_pkg::INTERVAL_MAX)
        else $error("retry interval out of range");
    chk_interval_gate: assert property (trip_here && s.limit == 4'h0 |=> s.st != fault_retry_pkg::ST_WAIT)
        else $error("retry started with zero limit");
    chk_estop_decel: assert property (estop_req && !$past(decel_stop_mode) |-> !emergency_decel_sel)
        else $error("emergency decel without decel stop mode");
    chk_wait_expire: assert property (s.st == fault_retry_pkg::ST_WAIT && wait_done
        |=> diag_req ##0 !speed_search_start)
        else $error("interval expiry did not start diagnosis");

endmodule : fault_retry_manager

// File: bench/fault_retry_manager_test.sv
// Self-checking bench for the fault retry manager: settings, retry flow, actions.
// Assumes a tick of four clocks, so one minute of running is 2400 cycles.
`timescale 1ns/10ps
module fault_retry_manager_test;
    logic pclk, presetn, psel, penable, pwrite, running, fault_trip, fault_reset, err;
    logic manual_restart, diag_done, diag_ok, cause_cleared, decel_stop_mode, pready;
    logic pslverr, diag_req, speed_search_start, stop_hold, fault_contact, irq;
    logic [4:0] det, act;
    logic [7:0] paddr;
    logic [5:0] fault_code;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, tests_run, cycles;

    fault_retry_manager #(.TICK_CYCLES(4)) fault_retry_manager_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .running(running), .fault_trip(fault_trip), .fault_code(fault_code),
        .fault_reset(fault_reset), .manual_restart(manual_restart), .diag_req(diag_req),
        .diag_done(diag_done), .diag_ok(diag_ok), .cause_cleared(cause_cleared),
        .pid_ref_loss(det[0]), .pid_fb_loss(det[1]), .pid_err_abn(det[2]),
        .eeprom_err(det[3]), .fram_err(det[4]), .decel_stop_mode(decel_stop_mode),
        .speed_search_start(speed_search_start), .stop_hold(stop_hold),
        .fault_contact(fault_contact), .alarm(act[4]), .stop_req(act[3]),
        .estop_req(act[2]), .coast_req(act[1]), .emergency_decel_sel(act[0]), .irq(irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // A hung handshake ends the run through the same verdict.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, m, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // The request is held until pready is seen; an idle edge follows each transfer.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic status(input logic [31:0] exp, input string m);
        apb(1'b0, 8'h10, 32'h0);
        check(rd & 32'h37f, exp, m);
    endtask : status

    task automatic trip(input logic [5:0] c);
        fault_code <= c;
        fault_trip <= 1'b1;
        @(posedge pclk);
        fault_trip <= 1'b0;
        @(posedge pclk);
    endtask : trip

    task automatic strobe(input logic restart);
        fault_reset <= ~restart;
        manual_restart <= restart;
        @(posedge pclk);
        fault_reset <= 1'b0;
        manual_restart <= 1'b0;
        @(posedge pclk);
    endtask : strobe

    task automatic diag(input logic ok);
        int n;
        n = 0;
        for (int i = 0; i < 40 && diag_req !== 1'b1; i++) @(posedge pclk);
        check(diag_req, 1'b1, "diag request");
        diag_done <= 1'b1;
        diag_ok <= ok;
        cause_cleared <= 1'b1;
        @(posedge pclk);
        diag_done <= 1'b0;
        repeat (3)
        begin
            @(posedge pclk);
            if (speed_search_start === 1'b1)
                n++;
        end
        check(n, ok, "speed search");
    endtask : diag

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] rst [4] = '{32'h0, 32'h64, 32'h0, 32'h11};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, rst[i], "reset value");
        end
        apb(1'b1, 8'h00, 32'h1f);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1a, "limit ceiling");
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h5, "interval floor");
        apb(1'b0, 8'h20, 32'h0);
        check({err, rd[30:0]}, 32'h80000000, "unmapped");
    endtask : t_regs

    task automatic t_retry();
        apb(1'b1, 8'h00, 32'h12);
        apb(1'b1, 8'h18, 32'h8);
        trip(6'h01);
        check(fault_contact, 1'b1, "contact in retry");
        repeat (14) @(posedge pclk);
        check(diag_req, 1'b0, "interval early");
        diag(1'b1);
        repeat (2300) @(posedge pclk);
        status(32'h031, "count kept");
        check(irq, 1'b0, "irq masked");
        repeat (120) @(posedge pclk);
        status(32'h000, "minute clears");
        check(irq, 1'b1, "irq raised");
        apb(1'b1, 8'h14, 32'h8);
        check(irq, 1'b0, "irq cleared");
    endtask : t_retry

    task automatic t_codes();
        logic nr;
        apb(1'b1, 8'h00, 32'ha);
        for (int c = 0; c < 64; c++)
        begin
            nr = c inside {[8:11], [14:18], [20:23], 26, 27, 34, 35, 37, 39, 43, 50, 51};
            trip(6'(c));
            status(nr ? 32'h340 : 32'h011, "retry class");
            if (!nr)
                diag(1'b0);
            strobe(1'b0);
        end
    endtask : t_codes

    task automatic t_lock();
        apb(1'b1, 8'h00, 32'h1);
        trip(6'h01);
        diag(1'b1);
        trip(6'h02);
        status(32'h341, "limit reached");
        check(stop_hold, 1'b1, "held");
        strobe(1'b1);
        status(32'h001, "restart keeps count");
        trip(6'h02);
        status(32'h341, "still at limit");
        strobe(1'b0);
        status(32'h000, "fault reset clears");
        apb(1'b1, 8'h00, 32'h0);
        trip(6'h01);
        status(32'h340, "limit zero");
        apb(1'b1, 8'h00, 32'h1);
        strobe(1'b0);
        trip(6'h01);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        status(32'h000, "power cycle clears");
    endtask : t_lock

    task automatic t_actions();
        logic [4:0] exp;
        for (int d = 0; d < 5; d++)
            for (int c = 0; c < 5; c++)
            begin
                decel_stop_mode <= d[0];
                apb(1'b1, d < 3 ? 8'h08 : 8'h0c, 32'(c) << (4 * (d % 3)));
                det <= 5'h1 << d;
                repeat (2) @(posedge pclk);
                exp = {c inside {[1:3]}, c == 2, c == 3, c == 4, c == 3 && d[0]};
                check(act, exp, "action decode");
                det <= 5'h0;
                @(posedge pclk);
            end
    endtask : t_actions

    initial
    begin
        {presetn, psel, penable, pwrite, fault_trip, fault_reset, manual_restart} = '0;
        {diag_done, diag_ok, cause_cleared, decel_stop_mode, det, fault_code} = '0;
        {paddr, pwdata, miscompares, tests_run, cycles} = '0;
        running = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_retry();
        t_codes();
        t_lock();
        t_actions();
        give_verdict();
    end
endmodule : fault_retry_manager_test
